// ===== fwdt_pkg.sv
package fwdt_pkg;
  // Register map: one aligned word
  localparam logic [11:0] CTRL_OFS      = 12'h0000;
  localparam logic [7:0]  CTRL_RST      = 8'h7F;
  localparam int          ACT_BIT       = 7;
  localparam int          TOP_BIT       = 6;
  // Prescaler: decrement every 16384 internal oscillator cycles
  localparam int          PRESC_CYCLES  = 16384;
  localparam int          PRESC_W       = 14;
  // Reset pulse length, 30 us at 25 MHz
  localparam int          RST_PULSE_NS  = 30000;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
  localparam int          PULSE_W       = 10;

  typedef struct packed {
    logic       act;
    logic [6:0] cnt;
  } fwdt_ctrl_t;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } fwdt_apb_req_t;
endpackage

// ===== fwdt_presc.sv
`timescale 1ns/1ps
module fwdt_presc (
  input  wire logic clk,  // System clock
  input  wire logic arst_n,  // Async reset, low
  output logic      tick  // One-cycle decrement enable
);
  typedef struct packed {
    logic [fwdt_pkg::PRESC_W-1:0] div;
    logic                         tick;
  } fwdt_presc_st_t;

  fwdt_presc_st_t st_r;
  fwdt_presc_st_t st_nxt;

  // Free-running divider; never cleared by register writes
  always_comb begin
    st_nxt      = st_r;
    st_nxt.div  = st_r.div + 1'b1;
    st_nxt.tick = (st_r.div == fwdt_pkg::PRESC_W'(fwdt_pkg::PRESC_CYCLES - 1));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// ===== fwdt_pulse.sv
`timescale 1ns/1ps
module fwdt_pulse (
  input  wire logic clk,  // System clock
  input  wire logic arst_n,  // Async reset, low
  input  wire logic trig,  // Start reset pulse
  output logic      rst_n_out  // Reset line, low while pulsing
);
  typedef struct packed {
    logic [fwdt_pkg::PULSE_W-1:0] cnt;
    logic                         low;
  } fwdt_pulse_st_t;

  fwdt_pulse_st_t st_r;
  fwdt_pulse_st_t st_nxt;

  // Fixed-length low pulse; retrigger during a pulse is absorbed
  always_comb begin
    st_nxt = st_r;
    if (st_r.low) begin
      if (st_r.cnt == fwdt_pkg::PULSE_W'(1)) begin
        st_nxt.low = 1'b0;
      end
      st_nxt.cnt = st_r.cnt - 1'b1;
    end else if (trig) begin
      st_nxt.low = 1'b1;
      st_nxt.cnt = fwdt_pkg::PULSE_W'(fwdt_pkg::RST_PULSE_CYC);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rst_n_out = ~st_r.low;
endmodule

// ===== fwdt_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module fwdt_top (
  input  wire logic        SYS_CLK,  // 25 MHz clock
  input  wire logic        ARST_N,  // Async reset, low
  input  wire logic        PSEL,  // APB select
  input  wire logic        PENABLE,  // APB enable
  input  wire logic        PWRITE,  // APB direction
  input  wire logic [11:0] PADDR,  // APB byte address
  input  wire logic [31:0] PWDATA,  // APB write data
  output logic      [31:0] PRDATA,  // APB read data
  output logic             PREADY,  // APB ready
  output logic             PSLVERR,  // APB error
  input  wire logic        HALT_EXEC,  // Halt instruction pulse
  input  wire logic        HALT_RESET_OPTION,  // Halt causes reset
  input  wire logic        HW_WDG_OPTION,  // Hardware watchdog mode
  output logic             WDG_RST_N  // Reset line, low active
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC  = 2'b01
  } fwdt_bus_t;

  typedef struct packed {
    fwdt_pkg::fwdt_ctrl_t ctrl;
    fwdt_bus_t            bus;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 err;
    logic                 trig;
    logic                 rst_n;
  } fwdt_st_t;

  fwdt_st_t              st_r;
  fwdt_st_t              st_nxt;
  fwdt_pkg::fwdt_apb_req_t req;
  logic                  tick;
  logic                  pulse_n;
  logic                  active;
  logic                  hit;
  logic                  wr_acc;
  logic [6:0]            dec_cnt;

  function automatic logic addr_hit(input logic [11:0] a);
    return a == fwdt_pkg::CTRL_OFS;
  endfunction

  assign req = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR, wdata: PWDATA};

  // Prescaler never reset by writes, so timeout spans a min and max
  fwdt_presc i_fwdt_presc (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .tick   (tick)
  );

  fwdt_pulse i_fwdt_pulse (
    .clk       (SYS_CLK),
    .arst_n    (ARST_N),
    .trig      (st_r.trig),
    .rst_n_out (pulse_n)
  );

  // Hardware option overrides the activation bit
  assign active  = HW_WDG_OPTION | st_r.ctrl.act;
  assign hit     = addr_hit(req.addr);
  assign wr_acc  = req.sel & req.en & st_r.ready & req.wr & hit;
  assign dec_cnt = st_r.ctrl.cnt - 7'h01;

  // Counter, activation, bus answer and reset triggers
  always_comb begin
    st_nxt       = st_r;
    st_nxt.trig  = 1'b0;
    st_nxt.ready = 1'b0;
    st_nxt.err   = 1'b0;
    // Line is re-registered here so the pin comes straight off a flop
    st_nxt.rst_n = pulse_n;
    if (tick) begin
      st_nxt.ctrl.cnt = dec_cnt;
      if (active && st_r.ctrl.cnt == 7'h40) begin
        st_nxt.trig = 1'b1;
      end
    end
    if (wr_acc) begin
      // Write loads all counter bits; a zero never clears activation
      st_nxt.ctrl.cnt = req.wdata[fwdt_pkg::TOP_BIT:0];
      st_nxt.ctrl.act = st_r.ctrl.act | req.wdata[fwdt_pkg::ACT_BIT];
      st_nxt.trig     = 1'b0;  // A reload in the same cycle beats the roll
      if ((active || req.wdata[fwdt_pkg::ACT_BIT]) && !req.wdata[fwdt_pkg::TOP_BIT]) begin
        st_nxt.trig = 1'b1;
      end
    end
    if (HALT_EXEC && active && HALT_RESET_OPTION) begin
      st_nxt.trig = 1'b1;
    end
    // APB: one wait state, ready in the second access cycle
    unique case (st_r.bus)
      ST_IDLE: begin
        if (req.sel && req.en && !st_r.ready) begin
          st_nxt.bus   = ST_ACC;
          st_nxt.ready = 1'b1;
          st_nxt.err   = ~hit;
          st_nxt.rdata = hit ? {24'h0000_00, st_r.ctrl.act, st_r.ctrl.cnt} : 32'h0000_0000;
        end
      end
      ST_ACC: begin
        st_nxt.bus = ST_IDLE;
      end
      default: begin
        st_nxt.bus = ST_IDLE;
      end
    endcase
  end

  // Reset leaves the register at 7Fh, watchdog inactive unless HW_WDG_OPTION is set
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r      <= '0;
      st_r.ctrl <= fwdt_pkg::CTRL_RST;
      st_r.bus   <= ST_IDLE;
      st_r.rst_n <= 1'b1;
    end else begin
      st_r      <= st_nxt;
    end
  end

  assign PRDATA    = st_r.rdata;
  assign PREADY    = st_r.ready;
  assign PSLVERR   = st_r.err;
  assign WDG_RST_N = st_r.rst_n;

  // Counter and prescaler: the count runs whether or not the watchdog is armed
  a_tick_dec: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && !wr_acc |=> st_r.ctrl.cnt == $past(st_r.ctrl.cnt) - 7'h01)
    else $error("counter did not decrement on tick");

  a_no_tick_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !tick && !wr_acc |=> st_r.ctrl.cnt == $past(st_r.ctrl.cnt))
    else $error("counter moved without tick");

  a_cnt_wraps: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && !wr_acc && st_r.ctrl.cnt == 7'h00 |=> st_r.ctrl.cnt == 7'h7F)
    else $error("counter did not wrap past zero");

  a_tick_gap: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick |=> (!tick)[*8])
    else $error("prescaler ticks too close together");

  a_tick_keeps_act: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && !wr_acc |=> st_r.ctrl.act == $past(st_r.ctrl.act))
    else $error("activation changed on a tick");

  // Activation and the hardware option
  a_act_sticky: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    st_r.ctrl.act |=> st_r.ctrl.act)
    else $error("activation bit cleared without reset");

  a_act_by_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(st_r.ctrl.act) |-> $past(wr_acc))
    else $error("activation set without write");

  a_act_write_set: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc && req.wdata[7] |=> st_r.ctrl.act)
    else $error("write of one did not activate");

  a_act_zero_keep: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc && !req.wdata[7] |=> st_r.ctrl.act == $past(st_r.ctrl.act))
    else $error("write of zero changed activation");

  a_hw_halt: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    HALT_EXEC && HW_WDG_OPTION && HALT_RESET_OPTION |=> st_r.trig)
    else $error("hardware mode halt gave no reset");

  a_hw_roll: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && HW_WDG_OPTION && st_r.ctrl.cnt == 7'h40 && !wr_acc |=> st_r.trig)
    else $error("hardware mode roll gave no reset");

  a_hw_sw_reset: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc && HW_WDG_OPTION && !req.wdata[6] |=> st_r.trig)
    else $error("hardware mode top bit clear gave no reset");

  // Reset generation and the reset line
  a_roll_reset: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && active && st_r.ctrl.cnt == 7'h40 && !wr_acc |-> ##3 !WDG_RST_N)
    else $error("no reset on 40h to 3Fh roll");

  a_sw_reset: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc && req.wdata[7] && !req.wdata[6] |-> ##3 !WDG_RST_N)
    else $error("software reset write ignored");

  a_halt_reset: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    HALT_EXEC && active && HALT_RESET_OPTION |=> st_r.trig)
    else $error("halt did not trigger reset");

  a_inactive_quiet: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !active && !HALT_EXEC && !wr_acc |=> !st_r.trig)
    else $error("reset triggered while inactive");

  a_roll_only_40: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tick && st_r.ctrl.cnt != 7'h40 && !HALT_EXEC && !wr_acc |=> !st_r.trig)
    else $error("reset triggered off the roll point");

  a_top_set_safe: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc && req.wdata[6] && !HALT_EXEC |=> !st_r.trig)
    else $error("reset triggered by a safe reload");

  a_halt_no_option: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    HALT_EXEC && !HALT_RESET_OPTION && !tick && !wr_acc |=> !st_r.trig)
    else $error("halt reset without the option");

  a_trig_single: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    st_r.trig && !HALT_EXEC && !tick && !wr_acc |=> !st_r.trig)
    else $error("reset trigger stuck high");

  a_trig_has_cause: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    st_r.trig |-> $past(tick || wr_acc || HALT_EXEC))
    else $error("reset trigger without a cause");

  a_trig_to_line: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    st_r.trig && pulse_n |-> ##2 !WDG_RST_N)
    else $error("trigger did not reach the reset line");

  a_line_follows: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    1'b1 |=> WDG_RST_N == $past(pulse_n))
    else $error("reset line does not follow the pulse");

  a_pulse_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $fell(WDG_RST_N) |-> (!WDG_RST_N)[*8])
    else $error("reset pulse too short");

  a_pulse_from_trig: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $fell(WDG_RST_N) |-> $past(st_r.trig, 2))
    else $error("reset pulse without a trigger");

  // Register bus answers
  a_ready_pulse: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  a_err_with_ready: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSLVERR |-> PREADY)
    else $error("error flag without ready");

  a_ready_on_access: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without an access phase");

  a_miss_answer: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSEL && PENABLE && !PREADY && st_r.bus == ST_IDLE && !hit |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");

  a_hit_answer: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSEL && PENABLE && !PREADY && st_r.bus == ST_IDLE && hit |=> PREADY && !PSLVERR)
    else $error("mapped access not answered");

  a_read_upper: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PREADY |-> PRDATA[31:8] == 24'h0000_00)
    else $error("upper read bits not zero");

  a_read_value: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PREADY && !PSLVERR |-> PRDATA[7:0] == $past(st_r.ctrl))
    else $error("read data differs from register");

  a_miss_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("refused read returned data");

  a_miss_no_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSEL && PENABLE && PREADY && PWRITE && !hit && !tick |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("unmapped write changed register");

  a_read_no_effect: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    PSEL && PENABLE && PREADY && !PWRITE && !tick |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("read changed register");

  a_write_load: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_acc |=> st_r.ctrl.cnt == $past(req.wdata[6:0]))
    else $error("write did not load counter");

  // State seen at the first edge after reset is released
  a_reset_state: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> st_r.ctrl == fwdt_pkg::CTRL_RST)
    else $error("register not at reset value");

  a_reset_outputs: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> WDG_RST_N && !PREADY && !PSLVERR && !st_r.ctrl.act)
    else $error("outputs or activation wrong after reset");
endmodule

// ===== fwdt_tb_top.sv
`timescale 1ns/1ps
module fwdt_tb_top;
  logic        SYS_CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        HALT_EXEC = 1'b0;
  logic        HALT_RESET_OPTION = 1'b0;
  logic        HW_WDG_OPTION = 1'b0;
  logic        WDG_RST_N;
  logic [31:0] rdat;
  logic        rerr;
  logic        lo_seen;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          tick_cyc;
  int          plen;
  int          t1;
  logic [31:0] v0;

  fwdt_top i_fwdt_top (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .HALT_EXEC(HALT_EXEC), .HALT_RESET_OPTION(HALT_RESET_OPTION),
    .HW_WDG_OPTION(HW_WDG_OPTION), .WDG_RST_N(WDG_RST_N));

  always #20 SYS_CLK = ~SYS_CLK;

  // Hang limit: most of a prescaler period beyond the planned run
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on pready itself, no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge SYS_CLK);
    ARST_N <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
  endtask

  task automatic wait_low(input int lim);
    int n;
    n = 0;
    while (WDG_RST_N !== 1'b0 && n < lim) begin
      @(posedge SYS_CLK);
      n++;
    end
    lo_seen = (WDG_RST_N === 1'b0);
    plen = 0;
    while (lo_seen && WDG_RST_N === 1'b0 && plen < 2000) begin
      @(posedge SYS_CLK);
      plen++;
    end
  endtask

  task automatic halt_pulse;
    @(posedge SYS_CLK);
    HALT_EXEC <= 1'b1;
    @(posedge SYS_CLK);
    HALT_EXEC <= 1'b0;
    wait_low(8);
  endtask

  // Main sequence; long waits come from the fixed 16384-cycle prescaler
  initial begin
    do_reset();
    apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rdat, {24'h00_0000, fwdt_pkg::CTRL_RST});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({rdat[30:0], rerr}, 32'h0000_0001);
    apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    v0 = rdat;
    while (rdat === v0) apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    t1 = cyc;
    chk(rdat, v0 - 1);
    v0 = rdat;
    while (rdat === v0) apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    tick_cyc = cyc;
    chk((tick_cyc - t1 + 8) / 16, 1024);
    chk({31'h0, WDG_RST_N}, 32'h0000_0001);
    apb(1'b1, fwdt_pkg::CTRL_OFS, 32'h0000_00C0);
    apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_00C0);
    apb(1'b1, fwdt_pkg::CTRL_OFS, 32'h0000_007F);
    apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_00FF);
    // One increment loaded: the first tick must pass quietly, the second trips
    apb(1'b1, fwdt_pkg::CTRL_OFS, 32'h0000_00C1);
    wait_low(16400);
    chk({31'h0, lo_seen}, 32'h0000_0000);
    wait_low(16400);
    chk({31'h0, lo_seen}, 32'h0000_0001);
    chk(((cyc - plen - tick_cyc + 8) % 16384) < 16, 32'h0000_0001);
    chk(plen, fwdt_pkg::RST_PULSE_CYC);
    do_reset();
    apb(1'b0, fwdt_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rdat & 32'h0000_0080, 32'h0000_0000);
    apb(1'b1, fwdt_pkg::CTRL_OFS, 32'h0000_00BF);
    wait_low(8);
    chk(plen, fwdt_pkg::RST_PULSE_CYC);
    do_reset();
    apb(1'b1, fwdt_pkg::CTRL_OFS, 32'h0000_00FF);
    halt_pulse();
    chk({31'h0, lo_seen}, 32'h0000_0000);
    HALT_RESET_OPTION <= 1'b1;
    halt_pulse();
    chk({31'h0, lo_seen}, 32'h0000_0001);
    HW_WDG_OPTION <= 1'b1;
    do_reset();
    halt_pulse();
    chk({31'h0, lo_seen}, 32'h0000_0001);
    finish_test();
  end
endmodule
